// file: verilog/rtcmr_pkg.sv
/*
  constants, types and rule summary shared by both ends of the 4-bit
  real-time clock control link (mode page, reset controller, selects).
  assumes a single 100 MHz core clock on each end and no other bus.
*/
`default_nettype none
package rtcmr_pkg;
  // register addresses
  localparam logic [3:0] ADDR_MODE = 4'hd;
  localparam logic [3:0] ADDR_TEST = 4'he;
  localparam logic [3:0] ADDR_RESET = 4'hf;
  localparam logic [3:0] ADDR_SEL1224 = 4'ha;
  localparam logic [3:0] ADDR_LEAP = 4'hb;
  localparam logic [3:0] ADDR_TEN_HOUR = 4'h5;
  // reset-controller fields
  localparam int RST_ALARM_BIT = 0;
  localparam int RST_PRESC_BIT = 1;
  localparam int RST_16HZ_N_BIT = 2;
  localparam int RST_1HZ_N_BIT = 3;
  // reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] RESETCTL_RESET = 4'hc;
  // calibration patterns the host uses
  localparam logic [3:0] CAL_16HZ = 4'h8;
  localparam logic [3:0] CAL_1HZ = 4'h4;
  // crystal time base: 32.768 kHz tick made from the core clock
  localparam int CORE_HZ = 100000000;
  localparam int XTAL_HZ = 32768;
  localparam int XTAL_DIV = CORE_HZ / XTAL_HZ;
  localparam int PRESC_BITS = 15;
  // host access pulse: strobe held low this long
  localparam int STROBE_NS = 400;
  localparam int STROBE_CYC = (STROBE_NS * (CORE_HZ / 1000000) + 999) / 1000;
  // idle gap after a strobe: the device lets go of the data pins only
  // after its synchroniser sees the strobe end, so the next write waits
  localparam int RECOVER_CYC = 6;
  // address map pages
  typedef enum logic [1:0] {
    RTCMR_PAGE_COUNT = 2'b00,
    RTCMR_PAGE_ALARM = 2'b01,
    RTCMR_PAGE_RAM0 = 2'b10,
    RTCMR_PAGE_RAM1 = 2'b11
  } rtcmr_page_t;
endpackage
`default_nettype wire

// file: verilog/rtcmr_if.sv
/*
  pin-level link between host and clock device.
  assumes the bench resolves the data wire from the two enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface rtcmr_if;
  logic cs; // high-true select from power-down detector
  logic cs_n; // low-true select from address decoder
  logic rd_n; // read strobe
  logic wr_n; // write strobe
  logic [3:0] addr; // address pins
  logic [3:0] host_d_o; // host data out
  logic host_d_oe; // host drives data
  logic [3:0] dev_d_o; // device data out
  logic dev_d_oe; // device drives data
  logic [3:0] d_i; // resolved data wire
  logic alarm_o; // alarm pin output value (always 0)
  logic alarm_oe; // open-drain pull low
  modport host (output cs, cs_n, rd_n, wr_n, addr, host_d_o, host_d_oe, input d_i, alarm_oe);
  modport dev (input cs, cs_n, rd_n, wr_n, addr, d_i, output dev_d_o, dev_d_oe, alarm_o, alarm_oe);
endinterface
`default_nettype wire

// file: verilog/rtcmr_dev.sv
/*
  device end: mode register, page decode, reset controller, leap and
  hour-format selectors, storage cells, prescaler and alarm pin.
  assumes asynchronous host strobes; they pass a 3-stage synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcmr_dev #(
  parameter int XTAL_DIV = rtcmr_pkg::XTAL_DIV
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // host pins
  rtcmr_if.dev LINK,
  // user side: alarm event and observed state
  input wire logic ALARM_EVENT,
  output logic [1:0] PAGE,
  output logic PM_FLAG,
  output logic LEAP_YEAR,
  output logic HOUR24,
  output logic SEC_TICK
);
  // raw strobe sampling: three stages each
  typedef struct packed {
    logic [2:0] rd_s;
    logic [2:0] wr_s;
    logic rd_act; // filtered qualified read level
    logic wr_act; // filtered qualified write level
    logic [1:0] mode; // page selector
    logic [1:0] en; // timer/alarm enable bits
    logic [3:0] test; // test register (write-only)
    logic [3:0] rst; // reset controller
    logic [1:0] leap; // leap counter
    logic sel24; // hour format
    logic [3:0] ten_hour; // tens-of-hours counter cell
    logic [3:0] year; // 1-year cell
    logic [12:0][3:0] alarm; // alarm page cells 0..C
    logic [12:0][3:0] ram0; // mode 10 storage
    logic [12:0][3:0] ram1; // mode 11 storage
    logic alarm_ff; // latched alarm indication
    logic [15:0] xdiv; // core-to-crystal divider
    logic [14:0] presc; // fifteen-stage prescaler
    logic sec_tick;
    logic [3:0] dout;
    logic doe;
    logic pin_low;
    logic pm; // afternoon indication, registered
    logic leap_yr; // leap-year indication, registered
  } rtcmr_dev_st_t;
  rtcmr_dev_st_t s_q, s_d;
  logic sel_ok; // both selects asserted
  logic rd_raw; // qualified read, unsynchronised
  logic wr_raw; // qualified write, unsynchronised
  logic wr_edge; // filtered write just began
  logic rd_now; // filtered read level
  logic xtick; // one crystal period elapsed
  logic [3:0] a; // address pins
  logic [3:0] wd; // data pins as seen by the device

  // page decode, shared by the write and read paths
  function automatic rtcmr_pkg::rtcmr_page_t page_of(input logic [1:0] m);
    return rtcmr_pkg::rtcmr_page_t'(m);
  endfunction

  // selects are combined with each strobe before sampling
  assign sel_ok = LINK.cs & ~LINK.cs_n;
  assign rd_raw = sel_ok & ~LINK.rd_n;
  assign wr_raw = sel_ok & ~LINK.wr_n;
  assign a = LINK.addr;
  assign wd = LINK.d_i;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.rd_s = {s_q.rd_s[1:0], rd_raw};
    s_d.wr_s = {s_q.wr_s[1:0], wr_raw};
    // change counts only when stages two and three agree; the price is
    // about four cycles of latency, so strobes must be far longer than that
    if (s_q.rd_s[1] == s_q.rd_s[2]) begin
      s_d.rd_act = s_q.rd_s[2];
    end
    if (s_q.wr_s[1] == s_q.wr_s[2]) begin
      s_d.wr_act = s_q.wr_s[2];
    end
    wr_edge = s_d.wr_act & ~s_q.wr_act;
    rd_now = s_q.rd_act;
    // crystal tick and prescaler
    xtick = (s_q.xdiv == 16'(XTAL_DIV - 1));
    s_d.xdiv = xtick ? 16'h0000 : s_q.xdiv + 16'h0001;
    s_d.sec_tick = 1'b0;
    if (xtick) begin
      s_d.presc = s_q.presc + 15'h0001;
      s_d.sec_tick = (s_q.presc == 15'h7fff);
    end
    // leap counter advances with each year cell step, on every sec_tick while en[1] is set
    if (s_q.sec_tick & s_q.en[1]) begin
      s_d.year = s_q.year + 4'h1;
      s_d.leap = s_q.leap + 2'b01;
    end
    // host write, on the rising edge of the qualified write level
    if (wr_edge) begin
      unique case (a)
        rtcmr_pkg::ADDR_MODE: begin
          // upper two bits carry the timer and alarm enables
          s_d.mode = wd[1:0];
          s_d.en = wd[3:2];
        end
        rtcmr_pkg::ADDR_TEST: s_d.test = wd;
        rtcmr_pkg::ADDR_RESET: begin
          s_d.rst = wd;
          if (wd[rtcmr_pkg::RST_ALARM_BIT]) begin
            s_d.alarm = '0;
            s_d.alarm_ff = 1'b0;
          end
          if (wd[rtcmr_pkg::RST_PRESC_BIT]) begin
            s_d.presc = '0;
            s_d.xdiv = '0;
          end
        end
        default: begin
          unique case (page_of(s_q.mode))
            rtcmr_pkg::RTCMR_PAGE_COUNT: begin
              if (a == rtcmr_pkg::ADDR_TEN_HOUR) begin
                s_d.ten_hour = {2'b00, wd[1:0]};
              end
              if (a == rtcmr_pkg::ADDR_LEAP) begin
                s_d.year = wd;
              end
            end
            rtcmr_pkg::RTCMR_PAGE_ALARM: begin
              if (a == rtcmr_pkg::ADDR_SEL1224) begin
                s_d.sel24 = wd[0];
              end else if (a == rtcmr_pkg::ADDR_LEAP) begin
                s_d.leap = wd[1:0];
              end else begin
                s_d.alarm[a] = wd;
              end
            end
            rtcmr_pkg::RTCMR_PAGE_RAM0: s_d.ram0[a] = wd;
            rtcmr_pkg::RTCMR_PAGE_RAM1: s_d.ram1[a] = wd;
          endcase
        end
      endcase
    end
    // alarm indication is sticky; an event in the cycle of a clear wins,
    // so an alarm is never lost to a clear racing it
    if (ALARM_EVENT & s_q.en[0]) begin
      s_d.alarm_ff = 1'b1;
    end
    // read data follows the address every cycle; drive waits for the
    // filtered read level
    s_d.doe = rd_now;
    s_d.dout = 4'h0;
    unique case (a)
      rtcmr_pkg::ADDR_MODE: s_d.dout = {s_q.en, s_q.mode};
      rtcmr_pkg::ADDR_TEST, rtcmr_pkg::ADDR_RESET: s_d.dout = 4'h0;
      default: begin
        unique case (page_of(s_q.mode))
          rtcmr_pkg::RTCMR_PAGE_COUNT: begin
            if (a == rtcmr_pkg::ADDR_TEN_HOUR) s_d.dout = s_q.ten_hour;
            else if (a == rtcmr_pkg::ADDR_LEAP) s_d.dout = s_q.year;
          end
          rtcmr_pkg::RTCMR_PAGE_ALARM: begin
            if (a == rtcmr_pkg::ADDR_SEL1224) s_d.dout = {3'b000, s_q.sel24};
            else if (a == rtcmr_pkg::ADDR_LEAP) s_d.dout = {2'b00, s_q.leap};
            else s_d.dout = s_q.alarm[a];
          end
          rtcmr_pkg::RTCMR_PAGE_RAM0: s_d.dout = s_q.ram0[a];
          rtcmr_pkg::RTCMR_PAGE_RAM1: s_d.dout = s_q.ram1[a];
        endcase
      end
    endcase
    // alarm pin: pulse trains take priority over the alarm flag
    if (!s_q.rst[rtcmr_pkg::RST_16HZ_N_BIT]) begin
      s_d.pin_low = ~s_q.presc[10];
    end else if (!s_q.rst[rtcmr_pkg::RST_1HZ_N_BIT]) begin
      s_d.pin_low = ~s_q.presc[14];
    end else begin
      s_d.pin_low = s_q.alarm_ff;
    end
    // status flags taken from the next state so the outputs are plain flops
    s_d.pm = ~s_d.sel24 & s_d.ten_hour[1];
    s_d.leap_yr = (s_d.leap == 2'b00);
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
      s_q.rst <= rtcmr_pkg::RESETCTL_RESET;
      s_q.leap_yr <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign LINK.dev_d_o = s_q.dout;
  assign LINK.dev_d_oe = s_q.doe;
  // open-drain pin: only the enable moves, the value stays low
  assign LINK.alarm_o = 1'b0;
  assign LINK.alarm_oe = s_q.pin_low;
  assign PAGE = s_q.mode;
  assign PM_FLAG = s_q.pm;
  assign LEAP_YEAR = s_q.leap_yr;
  assign HOUR24 = s_q.sel24;
  assign SEC_TICK = s_q.sec_tick;
endmodule
`default_nettype wire

// file: verilog/rtcmr_host.sv
/*
  host end: turns one-cycle user requests into select/strobe cycles.
  assumes the user waits for DONE before the next request.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcmr_host (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // pins
  rtcmr_if.host LINK,
  // user side
  input wire logic POWER_OK,
  input wire logic REQ,
  input wire logic WRITE,
  input wire logic [3:0] ADDR,
  input wire logic [3:0] WDATA,
  output logic DONE,
  output logic [3:0] RDATA,
  output logic BUSY
);
  typedef enum logic [1:0] {H_IDLE, H_STROBE, H_RECOVER} rtcmr_hst_t;
  typedef struct packed {
    rtcmr_hst_t st;
    logic [7:0] cnt;
    logic wr;
    logic [3:0] addr;
    logic [3:0] wdata;
    logic [3:0] rdata;
    logic done;
    logic [2:0] pwr_s;
    logic pwr; // filtered power-good level
    logic cs_n; // registered decoder select
    logic rd_n; // registered read strobe
    logic wr_n; // registered write strobe
    logic d_oe; // registered data drive
    logic busy; // registered busy level
  } rtcmr_host_st_t;
  rtcmr_host_st_t s_q, s_d;

  // sequencer: strobe low for STROBE_CYC, then RECOVER_CYC idle cycles
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.pwr_s = {s_q.pwr_s[1:0], POWER_OK};
    // power-good counts once stages two and three agree
    if (s_q.pwr_s[1] == s_q.pwr_s[2]) begin
      s_d.pwr = s_q.pwr_s[2];
    end
    unique case (s_q.st)
      H_IDLE: begin
        if (REQ) begin
          s_d.st = H_STROBE;
          s_d.wr = WRITE;
          s_d.addr = ADDR;
          s_d.wdata = WDATA;
          s_d.cnt = 8'(rtcmr_pkg::STROBE_CYC);
        end
      end
      H_STROBE: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h01) begin
          s_d.st = H_RECOVER;
          s_d.rdata = LINK.d_i;
          s_d.cnt = 8'(rtcmr_pkg::RECOVER_CYC);
        end
      end
      H_RECOVER: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h01) begin
          s_d.st = H_IDLE;
          s_d.done = 1'b1;
        end
      end
    endcase
    // pin levels decoded from the next state so they leave flip-flops
    s_d.cs_n = (s_d.st == H_IDLE);
    s_d.rd_n = ~((s_d.st == H_STROBE) & ~s_d.wr);
    s_d.wr_n = ~((s_d.st == H_STROBE) & s_d.wr);
    s_d.d_oe = (s_d.st == H_STROBE) & s_d.wr;
    s_d.busy = (s_d.st != H_IDLE);
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // power-good drives the high select, decode drives the low one
  assign LINK.cs = s_q.pwr;
  assign LINK.cs_n = s_q.cs_n;
  assign LINK.rd_n = s_q.rd_n;
  assign LINK.wr_n = s_q.wr_n;
  assign LINK.addr = s_q.addr;
  assign LINK.host_d_o = s_q.wdata;
  assign LINK.host_d_oe = s_q.d_oe;
  assign DONE = s_q.done;
  assign RDATA = s_q.rdata;
  assign BUSY = s_q.busy;
endmodule
`default_nettype wire

// file: test/rtcmr_properties.sv
/*
  checker on the host/device link pins.
  assumes the bench instantiates it beside its one link.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcmr_properties (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // selects and strobes
  input wire logic cs,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  // data and alarm pin
  input wire logic host_d_oe,
  input wire logic [3:0] dev_d_o,
  input wire logic dev_d_oe,
  input wire logic alarm_o,
  input wire logic alarm_oe
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // a read that both selects qualify
  sequence s_rd_sel; cs && !cs_n && !rd_n; endsequence
  // write strobe, select, data drive and address held for 8 cycles from the cycle after the strobe falls
  sequence s_wr_hold; (!wr_n && !cs_n && host_d_oe && $stable(addr))[*8]; endsequence
  property p_drive_sel; $rose(dev_d_oe) |-> s_rd_sel; endproperty
  property p_ef_zero; dev_d_oe && !rd_n && addr[3:1] == 3'h7 |-> dev_d_o == 4'h0; endproperty
  property p_no_fight; !(dev_d_oe && host_d_oe); endproperty
  property p_wr_hold; $fell(wr_n) |-> ##1 s_wr_hold; endproperty
  property p_wr_len; $fell(wr_n) |-> ##[38:42] $rose(wr_n); endproperty
  property p_release; $rose(rd_n) |-> ##[0:8] !dev_d_oe; endproperty
  property p_sel_cover; !rd_n || !wr_n |-> !cs_n; endproperty
  property p_one_strobe; !(!rd_n && !wr_n); endproperty
  // reset leaves both pulse trains off, so the pin is quiet
  property p_quiet_reset; $rose(RESETN) |-> (!alarm_oe && !alarm_o)[*8]; endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("data driven outside a selected read");
  a_ef_zero: assert property (p_ef_zero) else $error("write-only place read nonzero");
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  a_wr_hold: assert property (p_wr_hold) else $error("write request not held");
  a_wr_len: assert property (p_wr_len) else $error("write strobe length off");
  a_release: assert property (p_release) else $error("device kept data after read");
  a_sel_cover: assert property (p_sel_cover) else $error("strobe without decoder select");
  a_one_strobe: assert property (p_one_strobe) else $error("read and write strobes together");
  a_quiet_reset: assert property (p_quiet_reset) else $error("alarm pin active after reset");
endmodule
`default_nettype wire

// file: test/testbench.sv
/*
  bench: host and device joined by one link, driven from the host user side.
  assumes a pull-up on the data wire and a shortened crystal divider.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  // user-side stimulus, driven at the falling edge
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic power_ok = 1'b1;
  logic req = 1'b0;
  logic write = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] wdata = 4'h0;
  logic alarm_event = 1'b0;
  // observed outputs
  logic done, busy, pm_flag, leap_year, hour24, sec_tick;
  logic [3:0] rdata, q;
  logic [1:0] page;
  int mismatches = 0, n_checks = 0, cycles = 0, n;
  rtcmr_if link();
  // data wire: whoever enables wins, else the pull-up shows
  assign link.d_i = link.host_d_oe ? link.host_d_o : link.dev_d_oe ? link.dev_d_o : 4'hf;
  rtcmr_host i_rtcmr_host (.CORE_CLK(core_clk), .RESETN(resetn), .LINK(link.host), .POWER_OK(power_ok),
    .REQ(req), .WRITE(write), .ADDR(addr), .WDATA(wdata), .DONE(done), .RDATA(rdata), .BUSY(busy));
  // small divider keeps the pulse trains within the run
  rtcmr_dev #(.XTAL_DIV(2)) i_rtcmr_dev (.CORE_CLK(core_clk), .RESETN(resetn), .LINK(link.dev),
    .ALARM_EVENT(alarm_event), .PAGE(page), .PM_FLAG(pm_flag), .LEAP_YEAR(leap_year), .HOUR24(hour24),
    .SEC_TICK(sec_tick));
  rtcmr_properties i_rtcmr_properties (.CORE_CLK(core_clk), .RESETN(resetn), .cs(link.cs), .cs_n(link.cs_n),
    .rd_n(link.rd_n), .wr_n(link.wr_n), .addr(link.addr), .host_d_oe(link.host_d_oe), .dev_d_o(link.dev_d_o),
    .dev_d_oe(link.dev_d_oe), .alarm_o(link.alarm_o), .alarm_oe(link.alarm_oe));
  always #5 core_clk = ~core_clk;
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, well above the planned length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      summarize();
    end
  end
  // one transfer; REQ lasts one cycle, then DONE is awaited
  task automatic acc(input logic w, input logic [3:0] a, input logic [3:0] d);
    int k;
    @(negedge core_clk);
    req = 1'b1;
    write = w;
    addr = a;
    wdata = d;
    @(negedge core_clk);
    req = 1'b0;
    `CHK("busy", 1'b1, busy)
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 100);
    `CHK("done", 1'b1, done)
    `CHK("busy", 1'b0, busy)
    q = rdata;
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] e);
    acc(1'b0, a, 4'h0);
    `CHK("read", e, q)
  endtask
  // cycles until the alarm pin changes, at most lim
  task automatic twait(input int lim);
    logic v;
    v = link.alarm_oe;
    n = 0;
    while (link.alarm_oe === v && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("page", 2'h0, page)
    // every page, with the fixed places checked in each
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, rtcmr_pkg::ADDR_MODE, 4'h8 | 4'(m));
      `CHK("page", 2'(m), page)
      rd(rtcmr_pkg::ADDR_MODE, 4'h8 | 4'(m));
      acc(1'b1, rtcmr_pkg::ADDR_TEST, 4'h9);
      rd(rtcmr_pkg::ADDR_TEST, 4'h0);
      rd(rtcmr_pkg::ADDR_RESET, 4'h0);
      if (m > 1) begin
        acc(1'b1, 4'h0, 4'h5 + 4'(m));
        rd(4'h0, 4'h5 + 4'(m));
      end
    end
    // selector page: hour format and leap counter
    acc(1'b1, rtcmr_pkg::ADDR_MODE, 4'h1);
    acc(1'b1, rtcmr_pkg::ADDR_SEL1224, 4'hf);
    rd(rtcmr_pkg::ADDR_SEL1224, 4'h1);
    `CHK("hour24", 1'b1, hour24)
    acc(1'b1, rtcmr_pkg::ADDR_LEAP, 4'hf);
    rd(rtcmr_pkg::ADDR_LEAP, 4'h3);
    `CHK("leap", 1'b0, leap_year)
    acc(1'b1, rtcmr_pkg::ADDR_LEAP, 4'h4);
    `CHK("leap", 1'b1, leap_year)
    acc(1'b1, rtcmr_pkg::ADDR_SEL1224, 4'h0);
    `CHK("hour24", 1'b0, hour24)
    acc(1'b1, rtcmr_pkg::ADDR_MODE, 4'h0);
    acc(1'b1, rtcmr_pkg::ADDR_TEN_HOUR, 4'h2);
    `CHK("pm", 1'b1, pm_flag)
    acc(1'b1, rtcmr_pkg::ADDR_TEN_HOUR, 4'h1);
    `CHK("pm", 1'b0, pm_flag)
    // alarm flag and alarm registers cleared together
    acc(1'b1, rtcmr_pkg::ADDR_MODE, 4'h5);
    acc(1'b1, 4'h2, 4'h7);
    rd(4'h2, 4'h7);
    @(negedge core_clk);
    alarm_event = 1'b1;
    repeat (2) @(negedge core_clk);
    alarm_event = 1'b0;
    repeat (8) @(negedge core_clk);
    `CHK("alarm pin", 1'b1, link.alarm_oe)
    acc(1'b1, rtcmr_pkg::ADDR_RESET, 4'hd);
    `CHK("alarm pin", 1'b0, link.alarm_oe)
    rd(4'h2, 4'h0);
    // power fails: device must neither take nor answer
    @(negedge core_clk);
    power_ok = 1'b0;
    repeat (5) @(negedge core_clk);
    acc(1'b1, rtcmr_pkg::ADDR_MODE, 4'h3);
    rd(rtcmr_pkg::ADDR_MODE, 4'hf);
    power_ok = 1'b1;
    repeat (5) @(negedge core_clk);
    `CHK("page", 2'h1, page)
    rd(rtcmr_pkg::ADDR_MODE, 4'h5);
    // pulse trains: off, 16 Hz, then 1 Hz after a divider clear
    acc(1'b1, rtcmr_pkg::ADDR_RESET, 4'hc);
    twait(2500);
    `CHK("quiet pin", 2500, n)
    acc(1'b1, rtcmr_pkg::ADDR_RESET, rtcmr_pkg::CAL_16HZ);
    twait(2500);
    twait(2500);
    `CHK("16 Hz half period", 1'b1, n >= 2044 && n <= 2052)
    acc(1'b1, rtcmr_pkg::ADDR_RESET, rtcmr_pkg::CAL_1HZ | 4'h2);
    twait(40000);
    `CHK("1 Hz after clear", 1'b1, n >= 32700 && n <= 32770)
    summarize();
  end
endmodule
`default_nettype wire
